// file: hdl/sep_pkg.sv
package sep_pkg;

  // Fixed upper nibble of the slave address byte.
  localparam logic [3:0] DEV_TYPE = 4'ha;

  // Array and page geometry.
  localparam int MEM_AW = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PAGE_AW = 5;

  // Bit count at which a whole byte has been shifted.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Clock rate and self-timed write cycle.
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int WC_TIME_MS = 5;
  localparam int WC_CYCLES = WC_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int WC_CNT_W = 20;

  // Waits the bus master keeps after power-up; the device does not time them.
  localparam int POWERUP_TO_READ_DELAY_MS = 1;
  localparam int POWERUP_TO_WRITE_DELAY_MS = 1;

  // Values after reset.
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [MEM_AW-1:0] PTR_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;

  // Protocol phases of the slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WR,
    ST_RD,
    ST_WAIT
  } sep_state_t;

endpackage

// file: hdl/sep_mem_if.sv
interface sep_mem_if;
  logic we;
  logic [11:0] waddr;
  logic [7:0] wdata;
  logic [11:0] raddr;
  logic [7:0] rdata;

  // The slave writes and addresses the array; the array answers read data.
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport array (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: hdl/sep_mem.sv
module sep_mem (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  sep_mem_if.array mif // Array port from the slave.
);

  logic [7:0] cells [sep_pkg::MEM_DEPTH];

  // Writes land on the clock edge after the strobe.
  always_ff @(posedge mclk)
  begin
    if (mif.we)
      cells[mif.waddr] <= mif.wdata;
  end

  // Read data come out of a register one edge after the address.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      mif.rdata <= sep_pkg::BYTE_RESET;
    else
      mif.rdata <= cells[mif.raddr];
  end

endmodule // sep_mem

// file: hdl/sep_wcycle.sv
module sep_wcycle #(
  parameter logic [19:0] WC_CYCLES = 20'(sep_pkg::WC_CYCLES)
) (
  input wire logic mclk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic start, // One-cycle pulse that opens a write cycle.
  output logic busy // High while the write cycle runs.
);

  logic [19:0] remain;
  wire logic last = (remain == 20'h00001);

  // The counter runs down from the cycle length and drops busy at its end.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      remain <= 20'h00000;
      busy <= 1'b0;
    end
    else if (start)
    begin
      remain <= WC_CYCLES; // [RQ16]
      busy <= 1'b1; // [RQ9]
    end
    else if (busy)
    begin
      remain <= remain - 20'h00001;
      busy <= !last; // [RQ9]
    end
  end

endmodule // sep_wcycle

// file: hdl/sep_i2c_slave.sv
// Summary of operation
// [RQ1] The master makes clock, START and STOP; the device only listens and answers.
// [RQ2] Every bit in or out moves in step with the serial clock from the master.
// [RQ3] The data line is open drain: pulled low or released, never driven high.
// [RQ4] With write protect low, every array location accepts writes.
// [RQ5] With write protect high, programming is blocked; reads still work.
// [RQ6] A floating write protect pin counts as low, so the array stays writable.
// [RQ7] The three chip-select pins must equal the address bits of the slave byte.
// [RQ8] A floating chip-select pin counts as zero in address matching.
// [RQ9] After a STOP ending a write, the program cycle finishes within 5 ms.
// [RQ10] During the write cycle the bus side is deaf and the line stays released.
// [RQ11] The master waits 1 ms after power is stable before any access.
// [RQ12] The master picks the transfer direction; the device follows it.
// [RQ13] Slave byte is 1010, then three select bits, then read (1) or write (0).
// [RQ14] While busy, a START with the write address gets no acknowledge.
// [RQ15] When protected, addresses are acknowledged, the first data byte is not.
// [RQ16] A counter started by the STOP holds the bus side disabled until it ends.
module sep_i2c_slave #(
  parameter logic [19:0] WC_CYCLES = 20'(sep_pkg::WC_CYCLES)
) (
  input wire logic mclk, // System clock, 125 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic scl_in, // Serial clock pin from the master.
  input wire logic sda_in, // Serial data pin level.
  output logic sda_out, // Serial data drive level, always low.
  output logic sda_oe, // High while the device pulls the data line low.
  input wire logic write_protect, // High blocks programming of the array.
  input wire logic chip_select_bit0, // Strapped chip-select bit 0.
  input wire logic chip_select_bit1, // Strapped chip-select bit 1.
  input wire logic chip_select_bit2, // Strapped chip-select bit 2.
  output logic write_busy // High while the self-timed write cycle runs.
);

  localparam int NPIN = 6;

  sep_mem_if mif ();

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic scl_prev;
  logic sda_prev;
  sep_pkg::sep_state_t state;
  sep_pkg::sep_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic in_ack;
  logic next_in_ack;
  logic next_oe;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] txsr;
  logic [7:0] next_txsr;
  logic [11:0] ptr;
  logic [11:0] next_ptr;
  logic wp_lat;
  logic next_wp_lat;
  logic wrote;
  logic next_wrote;
  logic next_we;
  logic next_cycle_go;
  logic cycle_go;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;

  // All pins enter the mclk domain through two flip-flops each.
  assign pin_raw = {scl_in, sda_in, write_protect,
                    chip_select_bit2, chip_select_bit1, chip_select_bit0};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!reset_n)
        begin
          pin_meta[gi] <= sep_pkg::PIN_IDLE;
          pin_sync[gi] <= sep_pkg::PIN_IDLE;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins.
  wire logic scl_s = pin_sync[5];
  wire logic sda_s = pin_sync[4];
  wire logic wp_s = pin_sync[3]; // [RQ6]
  wire logic [2:0] cs_s = pin_sync[2:0]; // [RQ8]

  // Delayed copies give the edges of the serial clock and data line.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      scl_prev <= sep_pkg::PIN_IDLE;
      sda_prev <= sep_pkg::PIN_IDLE;
    end
    else
    begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // Bus events decoded from the sampled lines.
  wire logic scl_rise = scl_s & ~scl_prev; // [RQ2]
  wire logic scl_fall = ~scl_s & scl_prev; // [RQ2]
  wire logic scl_high = scl_s & scl_prev;
  wire logic start_c = scl_high & sda_prev & ~sda_s; // [RQ1]
  wire logic stop_c = scl_high & ~sda_prev & sda_s; // [RQ1]
  wire logic byte_done = (bit_cnt == sep_pkg::BYTE_BITS);
  wire logic active = (state != sep_pkg::ST_IDLE) && (state != sep_pkg::ST_WAIT);

  // The slave byte selects this device only when idle of any write cycle.
  wire logic type_ok = (shreg[7:4] == sep_pkg::DEV_TYPE); // [RQ13]
  wire logic cs_ok = (shreg[3:1] == cs_s); // [RQ7]
  wire logic addr_hit = type_ok && cs_ok && !write_busy; // [RQ10] [RQ14]
  wire logic rw_read = shreg[0]; // [RQ13]

  // Page writes wrap inside the page; reads run through the whole array.
  wire logic [11:0] ptr_page_inc = {ptr[11:sep_pkg::PAGE_AW],
                                    ptr[sep_pkg::PAGE_AW-1:0] + 5'h01};
  wire logic [11:0] ptr_inc = ptr + 12'h001;

  // Protocol sequencer; STOP outranks START, START outranks clock edges.
  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_in_ack = in_ack;
    next_oe = sda_oe;
    next_shreg = shreg;
    next_txsr = txsr;
    next_ptr = ptr;
    next_wp_lat = wp_lat;
    next_wrote = wrote;
    next_we = 1'b0;
    next_cycle_go = 1'b0;
    if (stop_c)
    begin
      next_state = sep_pkg::ST_IDLE;
      next_in_ack = 1'b0;
      next_oe = 1'b0;
      next_cycle_go = wrote; // [RQ9] [RQ16]
      next_wrote = 1'b0;
    end
    else if (start_c)
    begin
      next_state = sep_pkg::ST_DEV;
      next_bit_cnt = sep_pkg::CNT_RESET;
      next_in_ack = 1'b0;
      next_oe = 1'b0;
    end
    else if (active && scl_rise)
    begin
      if (!in_ack && !byte_done)
      begin
        next_shreg = {shreg[6:0], sda_s}; // [RQ2]
        next_bit_cnt = bit_cnt + 4'h1;
      end
      else if (in_ack && state == sep_pkg::ST_RD && sda_s)
        next_state = sep_pkg::ST_WAIT; // [RQ12]
    end
    else if (active && scl_fall)
    begin
      if (in_ack)
      begin
        // End of an acknowledge slot: release, then start the next byte.
        next_in_ack = 1'b0;
        next_bit_cnt = sep_pkg::CNT_RESET;
        next_oe = 1'b0;
        if (state == sep_pkg::ST_WR && !wrote)
          next_wp_lat = wp_s; // [RQ5]
        if (state == sep_pkg::ST_RD)
        begin
          next_txsr = mif.rdata;
          next_oe = ~mif.rdata[7]; // [RQ3]
          next_ptr = ptr_inc;
        end
      end
      else if (state == sep_pkg::ST_RD)
      begin
        if (byte_done)
        begin
          next_oe = 1'b0; // [RQ12]
          next_in_ack = 1'b1;
        end
        else
        begin
          next_txsr = {txsr[6:0], 1'b0};
          next_oe = ~txsr[6]; // [RQ2] [RQ3]
        end
      end
      else if (byte_done)
      begin
        next_in_ack = 1'b1;
        next_oe = 1'b1; // [RQ3]
        case (state)
          sep_pkg::ST_DEV:
          begin
            if (addr_hit)
              next_state = rw_read ? sep_pkg::ST_RD : sep_pkg::ST_AHI; // [RQ12]
            else
            begin
              next_state = sep_pkg::ST_WAIT; // [RQ10] [RQ14]
              next_in_ack = 1'b0;
              next_oe = 1'b0;
            end
          end
          sep_pkg::ST_AHI:
          begin
            next_ptr = {shreg[3:0], ptr[7:0]}; // [RQ15]
            next_state = sep_pkg::ST_ALO;
          end
          sep_pkg::ST_ALO:
          begin
            next_ptr = {ptr[11:8], shreg}; // [RQ15]
            next_state = sep_pkg::ST_WR;
          end
          sep_pkg::ST_WR:
          begin
            if (wp_lat)
            begin
              next_state = sep_pkg::ST_WAIT; // [RQ5] [RQ15]
              next_in_ack = 1'b0;
              next_oe = 1'b0;
            end
            else
            begin
              next_we = 1'b1; // [RQ4]
              next_ptr = ptr_page_inc;
              next_wrote = 1'b1;
            end
          end
          default:
          begin
            next_state = sep_pkg::ST_WAIT;
            next_in_ack = 1'b0;
            next_oe = 1'b0;
          end
        endcase
      end
    end
  end

  // Sequencer state and line drive.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state <= sep_pkg::ST_IDLE;
      bit_cnt <= sep_pkg::CNT_RESET;
      in_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      in_ack <= next_in_ack;
      sda_oe <= next_oe & ~write_busy; // [RQ10]
      sda_out <= 1'b0; // [RQ3]
    end
  end

  // Shift registers, address pointer and transfer flags.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      shreg <= sep_pkg::BYTE_RESET;
      txsr <= sep_pkg::BYTE_RESET;
      ptr <= sep_pkg::PTR_RESET;
      wp_lat <= 1'b0;
      wrote <= 1'b0;
      cycle_go <= 1'b0;
    end
    else
    begin
      shreg <= next_shreg;
      txsr <= next_txsr;
      ptr <= next_ptr;
      wp_lat <= next_wp_lat;
      wrote <= next_wrote;
      cycle_go <= next_cycle_go;
    end
  end

  // The write strobe carries the address from before the pointer moves.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wr_en <= 1'b0;
      wr_addr <= sep_pkg::PTR_RESET;
      wr_data <= sep_pkg::BYTE_RESET;
    end
    else
    begin
      wr_en <= next_we; // [RQ4]
      wr_addr <= ptr;
      wr_data <= shreg;
    end
  end

  // Array port: registered write strobe, read address follows the pointer.
  assign mif.we = wr_en;
  assign mif.waddr = wr_addr;
  assign mif.wdata = wr_data;
  assign mif.raddr = ptr;

  sep_mem u_mem (
    .mclk (mclk),
    .reset_n (reset_n),
    .mif (mif.array)
  );

  // Bytes land in the array as they arrive; the timer models the program time.
  sep_wcycle #(
    .WC_CYCLES (WC_CYCLES)
  ) u_wcycle (
    .mclk (mclk),
    .reset_n (reset_n),
    .start (cycle_go), // [RQ16]
    .busy (write_busy)
  );

endmodule // sep_i2c_slave

// file: dv/sep_i2c_slave_monitor.sv
module sep_i2c_slave_monitor #(
  parameter logic [19:0] WC_CYCLES = 20'(sep_pkg::WC_CYCLES)
) (
  input wire logic mclk, // Clock.
  input wire logic reset_n, // Reset.
  input wire logic scl_in, // Serial clock.
  input wire logic sda_in, // Data wire.
  input wire logic sda_out, // Drive level.
  input wire logic sda_oe, // Pull enable.
  input wire logic write_protect, // Protect pin.
  input wire logic chip_select_bit0, // Select 0.
  input wire logic chip_select_bit1, // Select 1.
  input wire logic chip_select_bit2, // Select 2.
  input wire logic write_busy // Busy flag.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] busy_cnt;
  logic [3:0] fall_age;
  logic [3:0] stop_age;
  logic in_frame;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Busy length, age of the last clock fall and STOP on the pins, frame state.
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      busy_cnt <= 20'h0;
      fall_age <= 4'hf;
      stop_age <= 4'hf;
      in_frame <= 1'b0;
    end
    else
    begin
      busy_cnt <= write_busy ? busy_cnt + 20'h1 : 20'h0;
      fall_age <= $fell(scl_in) ? 4'h0 : fall_age + 4'(fall_age != 4'hf);
      stop_age <= (scl_in && $rose(sda_in)) ? 4'h0 : stop_age + 4'(stop_age != 4'hf);
      in_frame <= (scl_in && $fell(sda_in)) || (in_frame && !(scl_in && $rose(sda_in)));
    end
  end
  // A started write cycle first holds for a run of cycles.
  sequence s_busy_hold;
    write_busy [*8];
  endsequence
  // Pin and write-cycle checks.
  AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  AST_BUSY_DEAF: assert property (write_busy |-> !sda_oe)
    else $error("answer during write cycle");
  AST_BUSY_LEN: assert property ($fell(write_busy) |-> busy_cnt == WC_CYCLES)
    else $error("write cycle length wrong");
  AST_BUSY_HOLD: assert property ($rose(write_busy) |-> s_busy_hold)
    else $error("write cycle ended early");
  AST_BUSY_CAUSE: assert property ($rose(write_busy) |-> stop_age < 4'hc)
    else $error("write cycle without STOP");
  AST_SDA_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data moved while clock high");
  AST_SDA_AFTER_FALL: assert property ($changed(sda_oe) |-> fall_age < 4'h8)
    else $error("data moved away from clock fall");
  AST_ANSWER_IN_FRAME: assert property ($rose(sda_oe) |-> in_frame)
    else $error("answer outside a frame");
endmodule // sep_i2c_slave_monitor

bind sep_i2c_slave sep_i2c_slave_monitor #(.WC_CYCLES(WC_CYCLES)) mon_u (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .chip_select_bit0(chip_select_bit0),
  .chip_select_bit1(chip_select_bit1), .chip_select_bit2(chip_select_bit2),
  .write_busy(write_busy));

// file: dv/sep_master_model.sv
module sep_master_model (
  input wire logic mclk, // System clock.
  input wire logic sda, // Resolved data wire.
  output logic scl, // Serial clock from the master.
  output logic sda_oe // High while the master pulls data low.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus idles with the clock high and data released.
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Waits a number of system clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // A quarter of the 125 ns serial clock period, free running against the system clock.
  task automatic quarter;
    #31.25;
  endtask
  // One clock pulse; data is sampled in the middle of the high phase.
  task automatic pulse(output logic b);
    quarter();
    scl <= 1'b1;
    quarter();
    b = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  // Bit transfers change data only while the clock is low.
  task automatic put_bit(input logic b);
    logic x;
    sda_oe <= !b;
    pulse(x);
  endtask
  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    pulse(b);
  endtask
  // Byte transfers, most significant bit first, with the ninth clock.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic nack;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(nack);
    ack = !nack;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic more);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(!more);
  endtask
  // Bus conditions made only by the master.
  task automatic start_c;
    sda_oe <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_oe <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic stop_c;
    sda_oe <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_oe <= 1'b0;
    tick(8);
  endtask
endmodule // sep_master_model

// file: dv/sep_i2c_slave_bench.sv
module sep_i2c_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] WC = 20'h000c8;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  logic scl;
  logic m_oe;
  logic sda_out;
  logic sda_oe;
  logic busy;
  int err_count = 0;
  int cmp_count = 0;
  // Pull-up on the data wire; any pulling party wins.
  wire sda = !(sda_oe || m_oe);
  // System clock, 8 ns period.
  always #4 mclk = !mclk;
  sep_i2c_slave #(.WC_CYCLES(WC)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(wp), .chip_select_bit0(cs[0]),
    .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .write_busy(busy));
  sep_master_model mdl (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
  // Compare tasks count every check and report each mismatch.
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bus access tasks built on the master model.
  task automatic send(input logic [7:0] d, input logic exp);
    logic ack;
    mdl.wr_byte(d, ack);
    chk_bit(ack, exp);
    chk_bit(sda_out, 1'b0);
  endtask
  task automatic addr(input logic [11:0] a);
    mdl.start_c();
    send({4'ha, cs, 1'b0}, 1'b1);
    send({4'h0, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask
  task automatic wr2(input logic [11:0] a, input logic [7:0] d0, d1, input logic ok);
    addr(a);
    send(d0, ok);
    if (ok)
      send(d1, 1'b1);
    mdl.stop_c();
    chk_bit(busy, ok);
  endtask
  task automatic rd(input logic [11:0] a, input int n, input logic [23:0] exp);
    logic [7:0] d;
    addr(a);
    mdl.start_c();
    send({4'ha, cs, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      mdl.rd_byte(d, i < n - 1);
      chk_byte(d, exp[23 - 8 * i -: 8]);
    end
    mdl.stop_c();
  endtask
  task automatic poll(input logic exp);
    mdl.start_c();
    send({4'ha, cs, 1'b0}, exp);
    mdl.stop_c();
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 400)
    begin
      @(posedge mclk);
      k++;
    end
    if (busy !== 1'b0)
    begin
      err_count++;
      $display("[FAIL] %0t: write cycle never ended", $time);
      report_and_stop();
    end
  endtask
  // Main sequence; low pins stand for floating protect and select inputs.
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    mdl.tick(16);
    wr2(12'h01f, 8'ha5, 8'h3c, 1'b1);
    poll(1'b0);
    wait_idle();
    poll(1'b1);
    $display("test write done");
    rd(12'h01f, 1, 24'ha50000);
    rd(12'h000, 1, 24'h3c0000);
    wr2(12'hffe, 8'h11, 8'h22, 1'b1);
    wait_idle();
    rd(12'hffe, 3, 24'h11223c);
    $display("test read done");
    @(posedge mclk);
    cs <= 3'h5;
    for (int c = 0; c < 8; c++)
    begin
      mdl.start_c();
      send({4'ha, 3'(c), 1'b0}, 3'(c) == 3'h5);
      mdl.stop_c();
    end
    mdl.start_c();
    send(8'hba, 1'b0);
    mdl.stop_c();
    $display("test select done");
    @(posedge mclk);
    wp <= 1'b1;
    wr2(12'h01f, 8'h77, 8'h00, 1'b0);
    rd(12'h01f, 1, 24'ha50000);
    $display("test protect done");
    report_and_stop();
  end
endmodule // sep_i2c_slave_bench
